// >>> common/exec_pkg.sv
package exec_pkg;

    // opcode encodings
    localparam logic [7:0] OPC_AND_DIR_IMM = 8'h53;
    localparam logic [7:0] OPC_AND_C_BIT   = 8'h82;
    localparam logic [7:0] OPC_AND_C_NBIT  = 8'hb0;
    localparam logic [7:0] OPC_CMP_A_IMM   = 8'hb4;
    localparam logic [7:0] OPC_CMP_A_DIR   = 8'hb5;
    localparam logic [6:0] OPC_CMP_IND_HI  = 7'h5b;
    localparam logic [3:0] OPC_CMP_REG_HI  = 4'hb;
    localparam int         OPC_REG_FLAG    = 3;

    // instruction lengths in bytes
    localparam logic [15:0] LEN_TWO   = 16'h0002;
    localparam logic [15:0] LEN_THREE = 16'h0003;

    // working register address: {pad, bank, register}
    localparam logic [2:0] REG_ADDR_PAD = 3'h0;
    localparam logic [1:0] PTR_SEL_PAD  = 2'h0;
    localparam int         BIT_VALUE    = 0;

    typedef enum logic [2:0] {
        kind_none        = 3'h0,
        kind_and_dir_imm = 3'h1,
        kind_and_c_bit   = 3'h2,
        kind_and_c_nbit  = 3'h3,
        kind_cmp_a_dir   = 3'h4,
        kind_cmp_a_imm   = 3'h5,
        kind_cmp_ind     = 3'h6,
        kind_cmp_reg     = 3'h7
    } op_kind_t;

    typedef enum logic [1:0] {
        space_direct = 2'h0,
        space_iram   = 2'h1,
        space_bit    = 2'h2
    } mem_space_t;

    typedef enum logic [2:0] {
        st_idle  = 3'h0,
        st_byte2 = 3'h1,
        st_byte3 = 3'h3,
        st_ptr   = 3'h2,
        st_oper  = 3'h6,
        st_exec  = 3'h7
    } exec_state_t;

endpackage

// >>> common/exec_if.sv
interface exec_if import exec_pkg::*; ();
    logic [7:0]  opcode;
    op_kind_t    kind;
    logic [2:0]  reg_sel;
    logic [15:0] length;
    logic        needs_byte3;
    logic [7:0]  op_a;
    logic [7:0]  op_b;
    logic [7:0]  rel;
    logic        carry_in;
    logic [15:0] pc_base;
    logic        carry_new;
    logic        taken;
    logic [15:0] pc_new;
    logic [7:0]  and_res;

    modport dec  (input opcode, output kind, reg_sel, length, needs_byte3);
    modport alu  (input kind, op_a, op_b, rel, carry_in, pc_base,
                  output carry_new, taken, pc_new, and_res);
    modport core (output opcode, op_a, op_b, rel, carry_in, pc_base,
                  input kind, reg_sel, length, needs_byte3,
                  carry_new, taken, pc_new, and_res);
endinterface

// >>> design/opcode_decoder.sv
module opcode_decoder
    import exec_pkg::*;
(
    exec_if.dec d    // opcode in, decoded fields out
);

    always_comb begin
        d.kind        = kind_none;
        d.reg_sel     = d.opcode[2:0];
        d.length      = LEN_TWO;
        d.needs_byte3 = 1'b0;
        if (d.opcode == OPC_AND_DIR_IMM) begin
            d.kind        = kind_and_dir_imm;
            d.length      = LEN_THREE;
            d.needs_byte3 = 1'b1;
        end else if (d.opcode == OPC_AND_C_BIT) begin
            d.kind = kind_and_c_bit;
        end else if (d.opcode == OPC_AND_C_NBIT) begin
            d.kind = kind_and_c_nbit;
        end else if (d.opcode == OPC_CMP_A_IMM) begin
            d.kind        = kind_cmp_a_imm;
            d.length      = LEN_THREE;
            d.needs_byte3 = 1'b1;
        end else if (d.opcode == OPC_CMP_A_DIR) begin
            d.kind        = kind_cmp_a_dir;
            d.length      = LEN_THREE;
            d.needs_byte3 = 1'b1;
        end else if (d.opcode[7:1] == OPC_CMP_IND_HI) begin
            d.kind        = kind_cmp_ind;
            d.reg_sel     = {PTR_SEL_PAD, d.opcode[0]};
            d.length      = LEN_THREE;
            d.needs_byte3 = 1'b1;
        end else if (d.opcode[7:4] == OPC_CMP_REG_HI && d.opcode[OPC_REG_FLAG]) begin
            d.kind        = kind_cmp_reg;
            d.length      = LEN_THREE;
            d.needs_byte3 = 1'b1;
        end
    end

endmodule

// >>> design/branch_alu.sv
module branch_alu
    import exec_pkg::*;
(
    exec_if.alu a    // operands in, results out
);

    logic is_cmp;

    always_comb begin
        is_cmp      = (a.kind == kind_cmp_a_dir) || (a.kind == kind_cmp_a_imm) ||
                      (a.kind == kind_cmp_ind) || (a.kind == kind_cmp_reg);
        a.and_res   = a.op_a & a.op_b;
        a.carry_new = a.carry_in;
        if (a.kind == kind_and_c_bit) begin
            a.carry_new = a.carry_in & a.op_b[BIT_VALUE];
        end else if (a.kind == kind_and_c_nbit) begin
            a.carry_new = a.carry_in & ~a.op_b[BIT_VALUE];
        end else if (is_cmp) begin
            a.carry_new = (a.op_a < a.op_b);
        end
        a.taken  = is_cmp && (a.op_a != a.op_b);
        // displacement added to the already advanced pc
        a.pc_new = a.taken ? a.pc_base + {{8{a.rel[7]}}, a.rel} : a.pc_base;
    end

endmodule

// >>> design/and_compare_branch_exec.sv
// Summary of operation
// - opcode 53h: direct byte AND immediate, three bytes
// - carry cleared when source bit is zero
// - complemented form inverts bit, bit untouched
// - direct bit source only, only carry changes
// - opcode 82h: carry AND bit, two bytes
// - opcode B0h: carry AND NOT bit
// - pc advanced, then signed offset if unequal
// - carry set when first operand is lower
// - four compare pairings, operands never written
// - accumulator versus direct byte, pc plus three
// - opcode B4h: accumulator versus immediate
// - opcodes B8h-BFh: working register versus immediate
// - opcodes B6h/B7h: indirect RAM versus immediate
module and_compare_branch_exec
    import exec_pkg::*;
(
    input  wire logic        clk,           // core clock
    input  wire logic        rst,           // async reset, active high
    input  wire logic        fetch_valid,   // instruction byte offered
    input  wire logic [7:0]  fetch_byte,    // instruction byte
    input  wire logic [15:0] fetch_pc,      // address of the opcode byte
    output logic             fetch_ready,   // byte taken when valid
    input  wire logic [7:0]  accumulator_reg, // accumulator contents
    input  wire logic [1:0]  bank_sel,      // active register bank
    input  wire logic        carry_in,      // current carry flag
    output logic             mem_rd_req,    // read request, held until valid
    output logic [1:0]       mem_space,     // read space: direct, iram, bit
    output logic [7:0]       mem_addr,      // read address
    input  wire logic        mem_rd_valid,  // read data returned
    input  wire logic [7:0]  mem_rd_data,   // read data, bit value in bit 0
    output logic             mem_wr_en,     // direct byte write pulse
    output logic [7:0]       mem_wr_addr,   // direct write address
    output logic [7:0]       mem_wr_data,   // direct write data
    output logic             carry_we,      // carry update pulse
    output logic             carry_out,     // new carry value
    output logic             pc_we,         // program counter update pulse
    output logic [15:0]      pc_out,        // next program counter
    output logic             done,          // instruction finished pulse
    output logic             unsupported    // opcode not handled here
);

    exec_if x ();

    opcode_decoder u_dec (
        .d (x.dec)
    );

    branch_alu u_alu (
        .a (x.alu)
    );

    exec_state_t state_q, state_d;
    logic [7:0]  opc_q, opc_d;
    logic [7:0]  byte2_q, byte2_d;
    logic [7:0]  byte3_q, byte3_d;
    logic [15:0] pc_q, pc_d;
    logic [7:0]  oper_a_q, oper_a_d;
    logic [7:0]  oper_b_q, oper_b_d;
    logic [7:0]  addr_q, addr_d;
    mem_space_t  space_q, space_d;
    logic        wr_en_q, wr_en_d;
    logic [7:0]  wr_addr_q, wr_addr_d;
    logic [7:0]  wr_data_q, wr_data_d;
    logic        carry_we_q, carry_we_d;
    logic        carry_q, carry_d;
    logic        pc_we_q, pc_we_d;
    logic [15:0] pc_out_q, pc_out_d;
    logic        done_q, done_d;
    logic        unsup_q, unsup_d;
    logic [7:0]  reg_addr;

    // decoder sees the incoming byte while idle, the held opcode after
    assign x.opcode   = (state_q == st_idle) ? fetch_byte : opc_q;
    assign x.op_a     = oper_a_q;
    assign x.op_b     = oper_b_q;
    assign x.rel      = byte3_q;
    assign x.carry_in = carry_in;
    assign x.pc_base  = pc_q;

    // working register or pointer in internal RAM
    assign reg_addr = {REG_ADDR_PAD, bank_sel, x.reg_sel};

    assign fetch_ready = (state_q == st_idle) || (state_q == st_byte2) ||
                         (state_q == st_byte3);
    assign mem_rd_req  = (state_q == st_ptr) || (state_q == st_oper);
    assign mem_space   = space_q;
    assign mem_addr    = addr_q;
    assign mem_wr_en   = wr_en_q;
    assign mem_wr_addr = wr_addr_q;
    assign mem_wr_data = wr_data_q;
    assign carry_we    = carry_we_q;
    assign carry_out   = carry_q;
    assign pc_we       = pc_we_q;
    assign pc_out      = pc_out_q;
    assign done        = done_q;
    assign unsupported = unsup_q;

    always_comb begin
        state_d    = state_q;
        opc_d      = opc_q;
        byte2_d    = byte2_q;
        byte3_d    = byte3_q;
        pc_d       = pc_q;
        oper_a_d   = oper_a_q;
        oper_b_d   = oper_b_q;
        addr_d     = addr_q;
        space_d    = space_q;
        wr_en_d    = 1'b0;
        wr_addr_d  = wr_addr_q;
        wr_data_d  = wr_data_q;
        carry_we_d = 1'b0;
        carry_d    = carry_q;
        pc_we_d    = 1'b0;
        pc_out_d   = pc_out_q;
        done_d     = 1'b0;
        unsup_d    = 1'b0;
        case (state_q)
            st_idle: begin
                if (fetch_valid) begin
                    if (x.kind == kind_none) begin
                        unsup_d = 1'b1;
                    end else begin
                        opc_d   = fetch_byte;
                        pc_d    = fetch_pc + x.length;
                        state_d = st_byte2;
                    end
                end
            end
            st_byte2: begin
                if (fetch_valid) begin
                    byte2_d = fetch_byte;
                    if (x.needs_byte3) begin
                        state_d = st_byte3;
                    end else begin
                        // bit operand only ever by direct bit address
                        addr_d  = fetch_byte;
                        space_d = space_bit;
                        state_d = st_oper;
                    end
                end
            end
            st_byte3: begin
                if (fetch_valid) begin
                    byte3_d = fetch_byte;
                    case (x.kind)
                        kind_and_dir_imm, kind_cmp_a_dir: begin
                            addr_d  = byte2_q;
                            space_d = space_direct;
                            state_d = st_oper;
                        end
                        kind_cmp_a_imm: begin
                            oper_a_d = accumulator_reg;
                            oper_b_d = byte2_q;
                            state_d  = st_exec;
                        end
                        kind_cmp_reg: begin
                            addr_d  = reg_addr;
                            space_d = space_iram;
                            state_d = st_oper;
                        end
                        kind_cmp_ind: begin
                            addr_d  = reg_addr;
                            space_d = space_iram;
                            state_d = st_ptr;
                        end
                        default: begin
                            state_d = st_idle;
                        end
                    endcase
                end
            end
            st_ptr: begin
                if (mem_rd_valid) begin
                    addr_d  = mem_rd_data;
                    space_d = space_iram;
                    state_d = st_oper;
                end
            end
            st_oper: begin
                if (mem_rd_valid) begin
                    state_d = st_exec;
                    case (x.kind)
                        kind_and_dir_imm: begin
                            oper_a_d = mem_rd_data;
                            oper_b_d = byte3_q;
                        end
                        kind_cmp_a_dir: begin
                            oper_a_d = accumulator_reg;
                            oper_b_d = mem_rd_data;
                        end
                        kind_cmp_reg, kind_cmp_ind: begin
                            oper_a_d = mem_rd_data;
                            oper_b_d = byte2_q;
                        end
                        default: begin
                            oper_a_d = mem_rd_data;
                            oper_b_d = mem_rd_data;
                        end
                    endcase
                end
            end
            st_exec: begin
                done_d   = 1'b1;
                pc_we_d  = 1'b1;
                pc_out_d = x.pc_new;
                state_d  = st_idle;
                if (x.kind == kind_and_dir_imm) begin
                    wr_en_d   = 1'b1;
                    wr_addr_d = byte2_q;
                    wr_data_d = x.and_res;
                end else begin
                    // only the carry flag is touched, no write-back
                    carry_we_d = 1'b1;
                    carry_d    = x.carry_new;
                end
            end
            default: begin
                state_d = st_idle;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q    <= st_idle;
            opc_q      <= 8'h00;
            byte2_q    <= 8'h00;
            byte3_q    <= 8'h00;
            pc_q       <= 16'h0000;
            oper_a_q   <= 8'h00;
            oper_b_q   <= 8'h00;
            addr_q     <= 8'h00;
            space_q    <= space_direct;
            wr_en_q    <= 1'b0;
            wr_addr_q  <= 8'h00;
            wr_data_q  <= 8'h00;
            carry_we_q <= 1'b0;
            carry_q    <= 1'b0;
            pc_we_q    <= 1'b0;
            pc_out_q   <= 16'h0000;
            done_q     <= 1'b0;
            unsup_q    <= 1'b0;
        end else begin
            state_q    <= state_d;
            opc_q      <= opc_d;
            byte2_q    <= byte2_d;
            byte3_q    <= byte3_d;
            pc_q       <= pc_d;
            oper_a_q   <= oper_a_d;
            oper_b_q   <= oper_b_d;
            addr_q     <= addr_d;
            space_q    <= space_d;
            wr_en_q    <= wr_en_d;
            wr_addr_q  <= wr_addr_d;
            wr_data_q  <= wr_data_d;
            carry_we_q <= carry_we_d;
            carry_q    <= carry_d;
            pc_we_q    <= pc_we_d;
            pc_out_q   <= pc_out_d;
            done_q     <= done_d;
            unsup_q    <= unsup_d;
        end
    end

endmodule

// >>> tb/and_compare_branch_exec_monitor.sv
module and_compare_branch_exec_monitor (
    input wire logic       clk,          // core clock
    input wire logic       rst,          // async reset
    input wire logic       fetch_ready,  // byte accepted
    input wire logic       mem_rd_req,   // read request
    input wire logic [1:0] mem_space,    // read space
    input wire logic [7:0] mem_addr,     // read address
    input wire logic       mem_rd_valid, // read returned
    input wire logic       mem_wr_en,    // byte write
    input wire logic       carry_we,     // carry update
    input wire logic       pc_we,        // pc update
    input wire logic       done,         // finished
    input wire logic       unsupported   // opcode not handled
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_done_pc;
        done |-> pc_we;
    endproperty
    a_done_pc: assert property (p_done_pc) else $error("done without pc update");
    property p_pc_done;
        pc_we |-> done;
    endproperty
    a_pc_done: assert property (p_pc_done) else $error("pc update without done");
    property p_carry_done;
        carry_we |-> done;
    endproperty
    a_carry_done: assert property (p_carry_done) else $error("stray carry update");
    property p_wr_alone;
        mem_wr_en |-> done && !carry_we;
    endproperty
    a_wr_alone: assert property (p_wr_alone) else $error("byte write with carry");
    property p_one_result;
        done |-> carry_we ^ mem_wr_en;
    endproperty
    a_one_result: assert property (p_one_result) else $error("wrong result kind");
    property p_done_pulse;
        done |=> !done [*2];
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done too close");
    property p_rd_hold;
        mem_rd_req && !mem_rd_valid |=> mem_rd_req && $stable(mem_addr) && $stable(mem_space);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read request dropped");
    property p_rd_stall;
        mem_rd_req |-> !fetch_ready;
    endproperty
    a_rd_stall: assert property (p_rd_stall) else $error("fetch open during read");
    property p_unsup_quiet;
        unsupported |-> !done && !mem_rd_req && !mem_wr_en;
    endproperty
    a_unsup_quiet: assert property (p_unsup_quiet) else $error("unhandled opcode acted");

    c_write: cover property (done && mem_wr_en);
    c_carry: cover property (done && carry_we);
    c_stall: cover property (mem_rd_req && !mem_rd_valid);
    c_unsup: cover property (unsupported);
endmodule

bind and_compare_branch_exec and_compare_branch_exec_monitor and_compare_branch_exec_monitor_i (
    .clk, .rst, .fetch_ready, .mem_rd_req, .mem_space, .mem_addr, .mem_rd_valid,
    .mem_wr_en, .carry_we, .pc_we, .done, .unsupported
);

// >>> tb/and_compare_branch_exec_tb.sv
module and_compare_branch_exec_tb
    import exec_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [15:0] pc;
        logic        cwe;
        logic        cy;
        logic        wr;
        logic [7:0]  wa;
        logic [7:0]  wd;
    } note_t;
    logic        clk, rst, fetch_valid, fetch_ready, carry_in, mem_rd_req, mem_rd_valid;
    logic        mem_wr_en, carry_we, carry_out, pc_we, done, unsupported;
    logic [7:0]  fetch_byte, accumulator_reg, mem_addr, mem_rd_data, mem_wr_addr, mem_wr_data;
    logic [15:0] fetch_pc, pc_out;
    logic [1:0]  bank_sel, mem_space, lat;
    logic [7:0]  dmem [256], imem [256], bmem [256];
    logic [7:0]  ops [7];
    note_t       notes [$];
    note_t       got;
    integer      seed = 32'h1067a1ab;
    int          fails, comparisons, issued, results, unsup, r, j, k;

    and_compare_branch_exec and_compare_branch_exec_i (
        .clk, .rst, .fetch_valid, .fetch_byte, .fetch_pc, .fetch_ready, .accumulator_reg,
        .bank_sel, .carry_in, .mem_rd_req, .mem_space, .mem_addr, .mem_rd_valid,
        .mem_rd_data, .mem_wr_en, .mem_wr_addr, .mem_wr_data, .carry_we, .carry_out,
        .pc_we, .pc_out, .done, .unsupported
    );

    initial clk = 1'b0;
    always #5 clk = ~clk;

    task automatic complete_run();
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // read responder: random latency, scrambled data while idle
    always @(negedge clk) begin
        if (mem_rd_valid) begin
            mem_rd_valid <= 1'b0;
            mem_rd_data  <= 8'($random(seed));
        end else if (mem_rd_req === 1'b1 && lat == 2'h0) begin
            mem_rd_valid <= 1'b1;
            mem_rd_data  <= mem_space == 2'h1 ? imem[mem_addr] :
                            mem_space == 2'h2 ? bmem[mem_addr] : dmem[mem_addr];
            lat          <= 2'($random(seed));
        end else if (mem_rd_req === 1'b1) begin
            lat <= lat - 2'h1;
        end
    end

    // result watcher against the oldest note
    always @(negedge clk) begin
        if (!rst && done === 1'b1) begin
            if (notes.size() == 0) begin
                fails++;
                $display("[FAIL] %0t result with nothing expected", $time);
            end else begin
                got = notes.pop_front();
                check(pc_out, got.pc);
                check(16'(carry_we), 16'(got.cwe));
                if (got.cwe) check(16'(carry_out), 16'(got.cy));
                check(16'(mem_wr_en), 16'(got.wr));
                if (got.wr) check({mem_wr_addr, mem_wr_data}, {got.wa, got.wd});
            end
            results++;
        end
        if (!rst && unsupported === 1'b1) unsup++;
    end

    task automatic give(input logic [7:0] v);
        int n;
        fetch_valid = 1'b1;
        fetch_byte  = v;
        for (n = 0; n < 50 && fetch_ready !== 1'b1; n++) @(negedge clk);
        @(negedge clk);
    endtask

    task automatic run(input logic [7:0] op, input logic [7:0] rel);
        logic [7:0]  a, b, b2;
        logic [15:0] pc0;
        logic        cmp;
        note_t       n;
        int          w;
        pc0 = (r == 2) ? 16'hfffe : 16'($random(seed));
        b2  = 8'($random(seed));
        n   = '0;
        fetch_pc        = pc0;
        accumulator_reg = 8'($random(seed));
        bank_sel        = 2'($random(seed));
        carry_in        = 1'($random(seed));
        cmp = op[7:4] == 4'hb && op != OPC_AND_C_NBIT;
        a = op[3] ? imem[{3'h0, bank_sel, op[2:0]}] :
            op[3:1] == 3'h3 ? imem[imem[{3'h0, bank_sel, 2'h0, op[0]}]] : accumulator_reg;
        if (cmp && $random(seed) % 2 == 0) begin
            if (op == OPC_CMP_A_DIR) dmem[b2] = accumulator_reg;
            else b2 = a;
        end
        b = (op == OPC_CMP_A_DIR) ? dmem[b2] : b2;
        if (op == OPC_AND_DIR_IMM) begin
            n = '{pc0 + LEN_THREE, 1'b0, 1'b0, 1'b1, b2, dmem[b2] & rel};
        end else if (!cmp) begin
            n = '{pc0 + LEN_TWO, 1'b1,
                  carry_in & (bmem[b2][0] ^ (op == OPC_AND_C_NBIT)), 1'b0, 8'h0, 8'h0};
        end else begin
            n.pc  = pc0 + LEN_THREE + (a != b ? {{8{rel[7]}}, rel} : 16'h0);
            n.cwe = 1'b1;
            n.cy  = a < b;
        end
        notes.push_back(n);
        issued++;
        give(op);
        give(b2);
        if (op != OPC_AND_C_BIT && op != OPC_AND_C_NBIT) give(rel);
        fetch_valid = 1'b0;
        fetch_byte  = ~rel;
        for (w = 0; w < 60 && results < issued; w++) @(negedge clk);
        if (results < issued) begin
            fails++;
            $display("[FAIL] %0t no result", $time);
        end
    endtask

    initial begin
        #100000;
        fails++;
        complete_run();
    end

    initial begin
        {rst, fetch_valid, fetch_byte, fetch_pc, accumulator_reg, bank_sel} = {1'b1, 35'h0};
        {carry_in, mem_rd_valid, mem_rd_data, lat} = 12'h0;
        ops = '{OPC_AND_DIR_IMM, OPC_AND_C_BIT, OPC_AND_C_NBIT, OPC_CMP_A_IMM,
                OPC_CMP_A_DIR, {OPC_CMP_IND_HI, 1'b0}, {OPC_CMP_IND_HI, 1'b1}};
        for (k = 0; k < 256; k++) begin
            dmem[k] = $random(seed);
            imem[k] = $random(seed);
            bmem[k] = $random(seed);
        end
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        check({15'h0, fetch_ready}, 16'h1);
        check(16'({done, pc_we, carry_we, mem_wr_en, mem_rd_req}), 16'h0);
        give(8'ha5);
        fetch_valid = 1'b0;
        repeat (3) @(negedge clk);
        check(16'(unsup), 16'h1);
        for (r = 0; r < 6; r++) begin
            for (j = 0; j < 7; j++) run(ops[j], r == 0 ? 8'h80 : r == 1 ? 8'h7f : 8'($random(seed)));
            for (j = 0; j < 8; j++) run({OPC_CMP_REG_HI, 1'b1, 3'(j)}, 8'($random(seed)));
        end
        repeat (4) @(negedge clk);
        complete_run();
    end
endmodule
